/* File: fts_burst_sram.sv */
// Purpose: access sequencing of a flow-through burst SRAM with no turnaround cycles
// Assumes: all pins synchronous to mclk; test clock sampled as a plain input
// Notes: data and parity pins split into in, out and one enable; wire resolved outside
`timescale 1ns/10ps

// Overview of operation
// - address sampled on rising edge; low two bits load the burst counter
// - lane written only with its strobe low in a burst loaded with write strobe low
// - write strobe sampled only on qualified edges; low starts a write
// - advance-or-load high advances counter; low accepts new address
// - clock qualify high freezes access and counter state (sleep and scan still run) and does not deselect
// - access starts with all selects active and advance-or-load low
// - read begins on qualified, selected, load edge with write strobe high
// - read data flows out in the cycle after the capturing edge
// - output enable low drives lines, high tri-states them at once
// - lines tri-stated in write data phase, on emerging, while deselected
// - any inactive select at a load edge deselects and tri-states
// - up to four beats per loaded address, counter wraps
// - strap low gives linear order, high or open gives interleaved
// - advance ignores chip selects and write strobe
// - direction captured at load, kept for the whole burst
// - write begins on qualified, selected, load edge with write strobe low
// - sleep request enters low power, keeps data; held low normally
// - new read, write or deselect may start on every qualified edge
// - incoming data captured on the rising edge
// - parity line handled like data under its own lane strobe
// - scan input sampled on test clock rise, output shifted on fall
// - write data taken one edge after address; new access same edge
// - interleaved beats xor beat index, linear adds it modulo four
// - lanes with strobe high keep stored contents
// - comes up deselected with all lines tri-stated
module fts_burst_sram (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [fts_pkg::ADDR_W-1:0] addr,
   input wire fts_pkg::fts_ctrl_t ctrl,
   input wire logic clock_qualify_n,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic burst_order,
   input wire fts_pkg::fts_io_t io_in,
   output fts_pkg::fts_io_t io_out,
   output logic io_oe,
   input wire logic test_clk,
   input wire logic test_mode_sel,
   input wire logic test_data_in,
   output logic test_data_out
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   fts_pkg::fts_op_t op_reg;
   fts_pkg::fts_op_t op_next;
   fts_pkg::fts_sleep_t sleep_st_reg;
   fts_pkg::fts_sleep_t sleep_st_next;
   logic [1:0] sleep_cnt_reg;
   logic [1:0] sleep_cnt_next;
   logic [fts_pkg::ADDR_W-3:0] hi_addr_reg;
   logic [fts_pkg::ADDR_W-3:0] hi_addr_next;
   logic wr_pend_reg;
   logic wr_pend_next;
   logic [fts_pkg::ADDR_W-1:0] wr_addr_reg;
   logic [fts_pkg::ADDR_W-1:0] wr_addr_next;
   logic [fts_pkg::LANES-1:0] wr_bw_reg;
   logic [fts_pkg::LANES-1:0] wr_bw_next;
   logic order_reg;
   logic order_next;
   logic strap_done_reg;
   logic strap_done_next;
   logic tck_prev_reg;
   logic tdi_cap_reg;
   logic tdi_cap_next;
   logic tdo_reg;
   logic tdo_next;
   logic awake;
   logic qual;
   logic selected;
   logic load;
   logic desel;
   logic advance;
   logic beat_edge;
   logic mem_we;
   logic mem_re;
   logic [fts_pkg::LANES-1:0] lane_en;
   logic [fts_pkg::BURST_W-1:0] low_next;
   logic [fts_pkg::BURST_W-1:0] low_reg;
   logic [fts_pkg::ADDR_W-1:0] access_addr;
   logic tck_rise;
   logic tck_fall;

   // ------------------------------------------------------------
   // edge qualification and decode
   // ------------------------------------------------------------
   assign awake = (sleep_st_reg == fts_pkg::FTS_AWAKE) && !sleep_request;
   assign qual = awake && !clock_qualify_n;
   assign selected = !ctrl.chip_select_one_n && ctrl.chip_select_two
                     && !ctrl.chip_select_three_n;
   assign load = qual && !ctrl.advance_or_load && selected;
   assign desel = qual && !ctrl.advance_or_load && !selected;
   // an advance while deselected stays deselected; a fresh load is needed
   assign advance = qual && ctrl.advance_or_load && (op_reg != fts_pkg::FTS_DESEL);
   assign beat_edge = load || advance;
   assign access_addr = {hi_addr_next, low_next};

   // ------------------------------------------------------------
   // burst strap, caught after reset release
   // ------------------------------------------------------------
   always_comb begin
      order_next = order_reg;
      strap_done_next = 1'b1;
      if (!strap_done_reg) begin
         order_next = burst_order;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         order_reg <= fts_pkg::ORDER_RST;
         strap_done_reg <= 1'b0;
      end else begin
         order_reg <= order_next;
         strap_done_reg <= strap_done_next;
      end
   end

   // ------------------------------------------------------------
   // access sequencing
   // ------------------------------------------------------------
   always_comb begin
      op_next = op_reg;
      hi_addr_next = hi_addr_reg;
      wr_pend_next = wr_pend_reg;
      wr_addr_next = wr_addr_reg;
      wr_bw_next = wr_bw_reg;
      if (!awake) begin
         // accesses pending on sleep entry are dropped
         if (sleep_request || (sleep_st_reg != fts_pkg::FTS_AWAKE)) begin
            op_next = fts_pkg::FTS_DESEL;
            wr_pend_next = 1'b0;
         end
      end else if (qual) begin
         if (load) begin
            hi_addr_next = addr[fts_pkg::ADDR_W-1:2];
            op_next = ctrl.write_n ? fts_pkg::FTS_READ : fts_pkg::FTS_WRITE;
         end else if (desel) begin
            op_next = fts_pkg::FTS_DESEL;
         end
         wr_pend_next = beat_edge && (op_next == fts_pkg::FTS_WRITE);
         wr_addr_next = access_addr;
         wr_bw_next = ctrl.byte_lane_write_n;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         op_reg <= fts_pkg::FTS_DESEL;
         hi_addr_reg <= fts_pkg::HI_ADDR_RST;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         wr_bw_reg <= fts_pkg::LANE_STROBE_RST;
      end else begin
         op_reg <= op_next;
         hi_addr_reg <= hi_addr_next;
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         wr_bw_reg <= wr_bw_next;
      end
   end

   fts_burst_counter u_counter (
      .clk(mclk),
      .arst_n(arst_n),
      .load(load),
      .advance(advance),
      .start_low(addr[1:0]),
      .interleave(order_reg),
      .low_next(low_next),
      .low_reg(low_reg)
   );

   // ------------------------------------------------------------
   // memory access
   // ------------------------------------------------------------
   // data pins are taken straight into the array at the data edge
   assign mem_we = qual && wr_pend_reg;
   assign lane_en = ~wr_bw_reg;
   assign mem_re = beat_edge && (op_next == fts_pkg::FTS_READ);

   fts_mem_array u_mem (
      .clk(mclk),
      .arst_n(arst_n),
      .wr_en(mem_we),
      .wr_addr(wr_addr_reg),
      .wr_lane_en(lane_en),
      .wr_data(io_in),
      .rd_en(mem_re),
      .rd_addr(access_addr),
      .rd_data(io_out)
   );

   // ------------------------------------------------------------
   // output drive
   // ------------------------------------------------------------
   // write and deselected cycles mask the enable, so no contention on turnaround
   assign io_oe = !output_enable_n && awake && (op_reg == fts_pkg::FTS_READ);

   // ------------------------------------------------------------
   // sleep entry and exit
   // ------------------------------------------------------------
   always_comb begin
      sleep_st_next = sleep_st_reg;
      sleep_cnt_next = sleep_cnt_reg;
      case (sleep_st_reg)
         fts_pkg::FTS_AWAKE: begin
            if (sleep_request) begin
               sleep_st_next = fts_pkg::FTS_ENTER;
               sleep_cnt_next = fts_pkg::SLEEP_CNT_RST;
            end
         end
         fts_pkg::FTS_ENTER: begin
            sleep_cnt_next = 2'(sleep_cnt_reg + 2'h1);
            if (!sleep_request) begin
               sleep_st_next = fts_pkg::FTS_WAKE;
               sleep_cnt_next = fts_pkg::SLEEP_CNT_RST;
            end else if (sleep_cnt_reg == fts_pkg::SLEEP_CNT_LAST) begin
               sleep_st_next = fts_pkg::FTS_ASLEEP;
            end
         end
         fts_pkg::FTS_ASLEEP: begin
            if (!sleep_request) begin
               sleep_st_next = fts_pkg::FTS_WAKE;
               sleep_cnt_next = fts_pkg::SLEEP_CNT_RST;
            end
         end
         default: begin
            sleep_cnt_next = 2'(sleep_cnt_reg + 2'h1);
            if (sleep_request) begin
               sleep_st_next = fts_pkg::FTS_ENTER;
               sleep_cnt_next = fts_pkg::SLEEP_CNT_RST;
            end else if (sleep_cnt_reg == fts_pkg::SLEEP_CNT_LAST) begin
               sleep_st_next = fts_pkg::FTS_AWAKE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sleep_st_reg <= fts_pkg::FTS_AWAKE;
         sleep_cnt_reg <= fts_pkg::SLEEP_CNT_RST;
      end else begin
         sleep_st_reg <= sleep_st_next;
         sleep_cnt_reg <= sleep_cnt_next;
      end
   end

   // ------------------------------------------------------------
   // scan port, single bypass stage
   // ------------------------------------------------------------
   assign tck_rise = test_clk && !tck_prev_reg;
   assign tck_fall = !test_clk && tck_prev_reg;

   always_comb begin
      tdi_cap_next = tdi_cap_reg;
      tdo_next = tdo_reg;
      if (tck_rise) begin
         tdi_cap_next = test_data_in && !test_mode_sel;
      end
      if (tck_fall) begin
         tdo_next = tdi_cap_reg;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tck_prev_reg <= 1'b0;
         tdi_cap_reg <= 1'b0;
         tdo_reg <= 1'b0;
      end else begin
         tck_prev_reg <= test_clk;
         tdi_cap_reg <= tdi_cap_next;
         tdo_reg <= tdo_next;
      end
   end

   assign test_data_out = tdo_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_READ_START: assert property (@(posedge mclk) disable iff (!arst_n)
      (load && ctrl.write_n) |=> (op_reg == fts_pkg::FTS_READ))
      else $error("read load did not start a read");

   AST_WRITE_DATA: assert property (@(posedge mclk) disable iff (!arst_n)
      ((load && !ctrl.write_n) ##1 qual) |-> mem_we)
      else $error("write data not taken on edge after address");

   AST_WRITE_TRI: assert property (@(posedge mclk) disable iff (!arst_n)
      (op_reg != fts_pkg::FTS_READ) |-> !io_oe)
      else $error("lines driven outside a read");

   AST_OE_HIGH: assert property (@(posedge mclk) disable iff (!arst_n)
      output_enable_n |-> !io_oe)
      else $error("lines driven with output enable high");

   AST_DESEL_TRI: assert property (@(posedge mclk) disable iff (!arst_n)
      desel |=> (!io_oe && (op_reg == fts_pkg::FTS_DESEL)))
      else $error("deselect edge left lines driven");

   AST_STALL_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
      (clock_qualify_n && awake) |=> ($stable(op_reg) && $stable(hi_addr_reg)
                                      && $stable(low_reg) && $stable(wr_pend_reg)))
      else $error("state changed on a stalled edge");

   AST_DIR_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
      advance |=> (op_reg == $past(op_reg)))
      else $error("burst direction changed on advance");

   AST_LINEAR_STEP: assert property (@(posedge mclk) disable iff (!arst_n)
      (advance && !order_reg) |=> (low_reg == 2'($past(low_reg) + 2'h1)))
      else $error("linear burst step wrong");

   AST_INTERLEAVE_FIRST: assert property (@(posedge mclk) disable iff (!arst_n)
      (load && order_reg) ##1 (advance && order_reg)
      |=> (low_reg == ($past(low_reg) ^ 2'h1)))
      else $error("interleaved second beat wrong");

   AST_SLEEP_ENTRY: assert property (@(posedge mclk) disable iff (!arst_n)
      ((sleep_st_reg == fts_pkg::FTS_AWAKE) && sleep_request) ##1 sleep_request[*2]
      |=> (sleep_st_reg == fts_pkg::FTS_ASLEEP))
      else $error("sleep not entered after two cycles");

   AST_SLEEP_TRI: assert property (@(posedge mclk) disable iff (!arst_n)
      sleep_request |-> (!io_oe && !mem_we))
      else $error("activity while sleep requested");

   AST_BACK_TO_BACK: assert property (@(posedge mclk) disable iff (!arst_n)
      load |=> (op_reg != fts_pkg::FTS_DESEL))
      else $error("selected load did not start an access");

   AST_SCAN_OUT: assert property (@(posedge mclk) disable iff (!arst_n)
      tck_fall |=> (test_data_out == $past(tdi_cap_reg)))
      else $error("scan output not shifted on test clock fall");

endmodule

/* File: fts_pkg.sv */
// Purpose: shared constants, carrier types and helpers of the flow-through burst SRAM core
// Assumes: 10 MHz mclk, four byte lanes of eight data lines plus one parity line
// Notes: burst order helper is used by the counter only; the checks in the top do not call it
package fts_pkg;

   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 21;
   localparam int LANES = 4;
   localparam int LANE_DATA_W = 8;
   localparam int DATA_W = LANES * LANE_DATA_W;
   localparam int BURST_W = 2;
   localparam int DEPTH = 1 << ADDR_W;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 100000;
   localparam int ACCESS_TIME_PS = 6500;
   // longest time, rounds down but never below one cycle
   localparam int ACCESS_CYCLES_RAW = ACCESS_TIME_PS / CLK_PERIOD_PS;
   localparam int ACCESS_CYCLES = (ACCESS_CYCLES_RAW < 1) ? 1 : ACCESS_CYCLES_RAW;
   // sleep entry and exit take two cycle times
   localparam int SLEEP_TCYC = 2;
   localparam int SLEEP_CYCLES = SLEEP_TCYC * CLK_PERIOD_PS / CLK_PERIOD_PS;
   localparam logic [1:0] SLEEP_CNT_LAST = 2'(SLEEP_CYCLES - 1);

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [ADDR_W-3:0] HI_ADDR_RST = 19'h00000;
   localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
   localparam logic [LANES-1:0] LANE_STROBE_RST = 4'hf;
   localparam logic [1:0] SLEEP_CNT_RST = 2'h0;
   localparam logic ORDER_RST = 1'b1;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {FTS_DESEL, FTS_READ, FTS_WRITE} fts_op_t;
   typedef enum logic [1:0] {FTS_AWAKE, FTS_ENTER, FTS_ASLEEP, FTS_WAKE} fts_sleep_t;

   typedef struct packed {
      logic chip_select_one_n;
      logic chip_select_two;
      logic chip_select_three_n;
      logic write_n;
      logic advance_or_load;
      logic [LANES-1:0] byte_lane_write_n;
   } fts_ctrl_t;

   typedef struct packed {
      logic [LANES-1:0] parity_lines;
      logic [DATA_W-1:0] data;
   } fts_io_t;

   // low address of a beat: xor in interleaved order, add modulo four in linear
   function automatic logic [BURST_W-1:0] fts_burst_addr(input logic [BURST_W-1:0] start,
                                                         input logic [BURST_W-1:0] beat,
                                                         input logic interleave);
      fts_burst_addr = interleave ? (start ^ beat) : 2'(start + beat);
   endfunction

endpackage

/* File: fts_mem_array.sv */
// Purpose: storage array with per-lane writes and a registered read port
// Assumes: one write and one read per clock, both on mclk
// Notes: a read of the word written at the same edge sees the new lanes
`timescale 1ns/10ps
module fts_mem_array (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wr_en,
   input wire logic [fts_pkg::ADDR_W-1:0] wr_addr,
   input wire logic [fts_pkg::LANES-1:0] wr_lane_en,
   input wire fts_pkg::fts_io_t wr_data,
   input wire logic rd_en,
   input wire logic [fts_pkg::ADDR_W-1:0] rd_addr,
   output fts_pkg::fts_io_t rd_data
);

   fts_pkg::fts_io_t mem [fts_pkg::DEPTH];
   fts_pkg::fts_io_t rd_next;

   // ------------------------------------------------------------
   // read with write forwarding
   // ------------------------------------------------------------
   always_comb begin
      rd_next = rd_data;
      if (rd_en) begin
         rd_next = mem[rd_addr];
         if (wr_en && (wr_addr == rd_addr)) begin
            for (int j = 0; j < fts_pkg::LANES; j++) begin
               if (wr_lane_en[j]) begin
                  rd_next.data[j*8 +: 8] = wr_data.data[j*8 +: 8];
                  rd_next.parity_lines[j] = wr_data.parity_lines[j];
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= rd_next;
      end
   end

   // ------------------------------------------------------------
   // lane writes, unselected lanes keep their contents
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (wr_en) begin
         for (int j = 0; j < fts_pkg::LANES; j++) begin
            if (wr_lane_en[j]) begin
               mem[wr_addr].data[j*8 +: 8] <= wr_data.data[j*8 +: 8];
               mem[wr_addr].parity_lines[j] <= wr_data.parity_lines[j];
            end
         end
      end
   end

endmodule

/* File: fts_burst_counter.sv */
// Purpose: two-bit burst counter, linear or interleaved
// Assumes: load and advance each mark a qualified clock edge
// Notes: low_next is the low address used at the current edge
`timescale 1ns/10ps
module fts_burst_counter (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic load,
   input wire logic advance,
   input wire logic [fts_pkg::BURST_W-1:0] start_low,
   input wire logic interleave,
   output logic [fts_pkg::BURST_W-1:0] low_next,
   output logic [fts_pkg::BURST_W-1:0] low_reg
);

   logic [fts_pkg::BURST_W-1:0] start_reg;
   logic [fts_pkg::BURST_W-1:0] start_next;
   logic [fts_pkg::BURST_W-1:0] beat_reg;
   logic [fts_pkg::BURST_W-1:0] beat_next;

   always_comb begin
      start_next = start_reg;
      beat_next = beat_reg;
      if (load) begin
         start_next = start_low;
         beat_next = fts_pkg::BURST_RST;
      end else if (advance) begin
         // wraps past the fourth beat
         beat_next = 2'(beat_reg + 2'h1);
      end
      low_next = fts_pkg::fts_burst_addr(start_next, beat_next, interleave);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         start_reg <= fts_pkg::BURST_RST;
         beat_reg <= fts_pkg::BURST_RST;
         low_reg <= fts_pkg::BURST_RST;
      end else begin
         start_reg <= start_next;
         beat_reg <= beat_next;
         low_reg <= low_next;
      end
   end

endmodule

/* File: fts_bus_model.sv */
// Purpose: controller side of the shared data and parity lines
// Assumes: drive and drive_data change after falling mclk
// Notes: undriven lines show the inverse of the last level, never a stale copy
`timescale 1ns/10ps
module fts_bus_model (
   input wire logic mclk,
   input wire logic drive,
   input wire fts_pkg::fts_io_t drive_data,
   input wire logic io_oe,
   input wire fts_pkg::fts_io_t io_out,
   output fts_pkg::fts_io_t io_in
);
   // ------------------------------------------------------------
   // wire resolution
   // ------------------------------------------------------------
   fts_pkg::fts_io_t last_reg = 36'h0;
   always_comb begin
      if (io_oe) begin
         io_in = io_out;
      end else if (drive) begin
         io_in = drive_data;
      end else begin
         io_in = ~last_reg;
      end
   end
   always_ff @(posedge mclk) begin
      last_reg <= io_in;
   end
endmodule

/* File: flow_through_burst_sram_access_bench.sv */
// Purpose: self-checking bench of the flow-through burst SRAM core
// Assumes: inputs change on falling mclk, outputs looked at 10 ns after the rise, io_oe after enable or sleep changes 1 ns after the fall
// Notes: strap is only taken after reset, so each burst order gets its own reset
`timescale 1ns/10ps
module flow_through_burst_sram_access_bench;
   // ------------------------------------------------------------
   // stimulus and checks
   // ------------------------------------------------------------
   localparam fts_pkg::fts_ctrl_t RD = 9'h0af;
   localparam fts_pkg::fts_ctrl_t WR = 9'h080;
   localparam fts_pkg::fts_ctrl_t ADV = 9'h150;
   localparam fts_pkg::fts_ctrl_t DESEL = 9'h1af;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [fts_pkg::ADDR_W-1:0] addr = 21'h000000;
   fts_pkg::fts_ctrl_t ctrl = DESEL;
   logic clock_qualify_n = 1'b0;
   logic output_enable_n = 1'b0;
   logic sleep_request = 1'b0;
   logic burst_order = 1'b0;
   logic drv = 1'b0;
   fts_pkg::fts_io_t wdata = 36'h0;
   fts_pkg::fts_io_t io_in;
   fts_pkg::fts_io_t io_out;
   fts_pkg::fts_io_t e;
   logic io_oe;
   logic test_clk = 1'b0;
   logic test_data_in = 1'b0;
   logic test_data_out;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;

   fts_burst_sram dut (.mclk(mclk), .arst_n(arst_n), .addr(addr), .ctrl(ctrl),
      .clock_qualify_n(clock_qualify_n), .output_enable_n(output_enable_n),
      .sleep_request(sleep_request), .burst_order(burst_order), .io_in(io_in),
      .io_out(io_out), .io_oe(io_oe), .test_clk(test_clk), .test_mode_sel(1'b0),
      .test_data_in(test_data_in), .test_data_out(test_data_out));
   fts_bus_model ctl (.mclk(mclk), .drive(drv), .drive_data(wdata), .io_oe(io_oe),
      .io_out(io_out), .io_in(io_in));

   always #50 mclk = ~mclk;

   // hang guard: the whole sequence needs well under 200 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         complete_run();
      end
   end

   function automatic fts_pkg::fts_io_t pat(input int k);
      pat = {4'(k) ^ 4'h9, 32'hc3a5_0000 + 32'(k)};
   endfunction

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic step(input fts_pkg::fts_ctrl_t c, input logic [20:0] a, input logic d,
                       input fts_pkg::fts_io_t w);
      @(negedge mclk);
      ctrl = c;
      addr = a;
      drv = d;
      wdata = w;
      @(posedge mclk);
      #10;
   endtask

   task automatic do_reset(input logic order);
      @(negedge mclk);
      arst_n = 1'b0;
      burst_order = order;
      drv = 1'b0;
      ctrl = DESEL;
      repeat (5) @(negedge mclk);
      arst_n = 1'b1;
      @(posedge mclk);
      #10;
      chk({35'h0, io_oe}, 36'h0);
   endtask

   // linear write burst from low address 1, then read burst with selects off
   task automatic linear_burst();
      step(WR, 21'h000011, 1'b0, 36'h0);
      for (int k = 0; k < 4; k++) begin
         chk({35'h0, io_oe}, 36'h0);
         step((k < 3) ? ADV : RD, 21'h000011, 1'b1, pat(k));
      end
      for (int k = 0; k < 5; k++) begin
         chk(io_out, pat(k % 4));
         chk({35'h0, io_oe}, 36'h1);
         if (k < 4) step(ADV, 21'h1fffff, 1'b0, 36'h0);
      end
   endtask

   // stall, deselect, advance while deselected, output enable
   task automatic stall_desel();
      @(negedge mclk);
      clock_qualify_n = 1'b1;
      ctrl = DESEL;
      repeat (3) @(posedge mclk);
      #10;
      chk(io_out, pat(0));
      chk({35'h0, io_oe}, 36'h1);
      @(negedge mclk);
      clock_qualify_n = 1'b0;
      @(posedge mclk);
      #10;
      chk({35'h0, io_oe}, 36'h0);
      step(ADV, 21'h000011, 1'b0, 36'h0);
      chk({35'h0, io_oe}, 36'h0);
      step(RD, 21'h000012, 1'b0, 36'h0);
      chk(io_out, pat(1));
      @(negedge mclk);
      output_enable_n = 1'b1;
      #1;
      chk({35'h0, io_oe}, 36'h0);
      @(negedge mclk);
      output_enable_n = 1'b0;
      #1;
      chk({35'h0, io_oe}, 36'h1);
   endtask

   // lanes 0 and 2 written with ones, read back at the data edge, then sleep
   task automatic lanes_sleep();
      e = pat(1) | 36'h5_00ff_00ff;
      step({5'h08, 4'ha}, 21'h000012, 1'b0, 36'h0);
      step(RD, 21'h000012, 1'b1, 36'hf_ffff_ffff);
      chk(io_out, e);
      @(negedge mclk);
      sleep_request = 1'b1;
      ctrl = DESEL;
      drv = 1'b0;
      #1;
      chk({35'h0, io_oe}, 36'h0);
      repeat (4) @(negedge mclk);
      sleep_request = 1'b0;
      repeat (4) @(negedge mclk);
      step(RD, 21'h000012, 1'b0, 36'h0);
      chk(io_out, e);
   endtask

   // back-to-back single writes, interleaved read burst from low address 2
   task automatic interleaved_burst();
      for (int k = 0; k < 4; k++) begin
         step(WR, 21'h000020 + 21'(k), k > 0, pat(k + 7));
      end
      step(RD, 21'h000022, 1'b1, pat(11));
      for (int k = 0; k < 4; k++) begin
         chk(io_out, pat(8 + (2 ^ k)));
         step(ADV, 21'h000000, 1'b0, 36'h0);
      end
   endtask

   // one bit in on a test clock rise, out on the following fall, not before
   task automatic scan_shift();
      for (int k = 0; k < 2; k++) begin
         @(negedge mclk);
         test_data_in = (k == 0);
         test_clk = 1'b1;
         @(posedge mclk);
         #10;
         chk({35'h0, test_data_out}, {35'h0, k == 1});
         @(negedge mclk);
         test_clk = 1'b0;
         @(posedge mclk);
         #10;
         chk({35'h0, test_data_out}, {35'h0, k == 0});
      end
   endtask

   initial begin
      do_reset(1'b0);
      linear_burst();
      stall_desel();
      lanes_sleep();
      do_reset(1'b1);
      interleaved_burst();
      scan_shift();
      complete_run();
   end
endmodule
